//--- shared/cxop_regs.svh
// Constants of the execution datapath (push..wait group)
// Assumes inclusion by the core only
`ifndef CXOP_REGS_SVH
`define CXOP_REGS_SVH
`define CXOP_WORD_BYTES   32'h0000_0004
`define CXOP_FLAG_RST     1'b0
`define CXOP_ENTRY_SCALE  1
`endif

//--- shared/cxop_pkg.sv
// Types of the execution datapath
// Assumes a single core clock domain
package cxop_pkg;
    typedef enum logic [4:0] {
        CXOP_NOP        = 5'h00,
        CXOP_WBSWAP     = 5'h01,
        CXOP_HPSWAP     = 5'h02,
        CXOP_LHSWAPSX   = 5'h03,
        CXOP_SLMUL      = 5'h04,
        CXOP_ULMUL      = 5'h05,
        CXOP_SMAC       = 5'h06,
        CXOP_UMAC       = 5'h07,
        CXOP_SCLIP      = 5'h08,
        CXOP_UCLIP      = 5'h09,
        CXOP_BLKASC     = 5'h0A,
        CXOP_BLKDESC    = 5'h0B,
        CXOP_PUSH       = 5'h0C,
        CXOP_DWSTORE    = 5'h0D,
        CXOP_EXSTORE    = 5'h0E,
        CXOP_SFEXT      = 5'h0F,
        CXOP_UFEXT      = 5'h10,
        CXOP_HSEXT      = 5'h11,
        CXOP_BSEXT      = 5'h12,
        CXOP_HZEXT      = 5'h13,
        CXOP_BZEXT      = 5'h14,
        CXOP_TJHALF     = 5'h15,
        CXOP_TJBYTE     = 5'h16,
        CXOP_RBIT       = 5'h17
    } cxop_op_e;
    typedef enum logic [1:0] {
        CXOP_S_IDLE  = 2'b00,
        CXOP_S_STORE = 2'b01,
        CXOP_S_TABLE = 2'b11
    } cxop_state_e;
    typedef enum logic [1:0] {
        CXOP_SZ_BYTE = 2'b00,
        CXOP_SZ_HALF = 2'b01,
        CXOP_SZ_WORD = 2'b10
    } cxop_size_e;
endpackage

//--- core/cxop_exec.sv
// Execution datapath: reversals, long multiplies, clipping, extends,
// field extracts, table jumps, block/doubleword/exclusive stores.
// Assumes the core supplies register values and accepts one op when idle.
// Contract
// - Word byte swap reverses all four bytes of the source.
// - Halfword pair byte swap swaps bytes inside each half independently.
// - Low half swap then sign extends the 16-bit result.
// - Signed long multiply gives full 64-bit product in low/high.
// - Unsigned long multiply gives full 64-bit product in low/high.
// - Signed long mac adds signed product to the 64-bit pair.
// - Unsigned long mac adds unsigned product to the 64-bit pair.
// - Clip ops take bit position, right-rotated source; only they touch flag.
// - Ascending block store increments after each word; optional writeback.
// - Descending block store decrements before each word; optional writeback.
// - Push stores below stack pointer; pointer ends at lowest word.
// - Doubleword store writes two words at base plus offset.
// - Exclusive store writes only with reservation; reports status.
// - Signed field extract sign-extends from the field top bit.
// - Unsigned field extract clears bits above the field.
// - Sign extend halves or bytes after optional right rotate.
// - Zero extend halves or bytes after optional right rotate.
// - Half table jump reads base plus index times two; pc plus 2*entry.
`include "cxop_regs.svh"
module cxop_exec
    import cxop_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_valid,
    input  wire cxop_op_e    i_op,
    input  wire logic [31:0] i_rn,
    input  wire logic [31:0] i_rm,
    input  wire logic [31:0] i_acc_lo,
    input  wire logic [31:0] i_acc_hi,
    input  wire logic [31:0] i_imm,
    input  wire logic [4:0]  i_rot,
    input  wire logic [4:0]  i_lsb,
    input  wire logic [5:0]  i_width,
    input  wire logic [15:0] i_reglist,
    input  wire logic        i_writeback,
    input  wire cxop_size_e  i_ex_size,
    input  wire logic        i_ex_held,
    input  wire logic [31:0] i_pc,
    input  wire logic [31:0] i_reg_rdata,
    input  wire logic        i_mem_ready,
    input  wire logic [31:0] i_mem_rdata,
    output logic             o_busy,
    output logic             o_done,
    output logic [31:0]      o_res_lo,
    output logic [31:0]      o_res_hi,
    output logic             o_res_hi_we,
    output logic             o_base_we,
    output logic [31:0]      o_base_val,
    output logic             o_pc_we,
    output logic             o_sat_flag,
    output logic [3:0]       o_reg_idx,
    output logic             o_mem_req,
    output logic             o_mem_we,
    output logic [31:0]      o_mem_addr,
    output logic [31:0]      o_mem_wdata,
    output cxop_size_e       o_mem_size,
    output logic             o_ex_clear
);
    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [31:0] rotr(input logic [31:0] v, input logic [4:0] n);
        rotr = (v >> n) | (v << (6'd32 - {1'b0, n}));
    endfunction
    function automatic logic [4:0] popc(input logic [15:0] l);
        logic [4:0] c;
        c = 5'd0;
        for (int k = 0; k < 16; k++) begin
            c = c + {4'd0, l[k]};
        end
        popc = c;
    endfunction
    function automatic logic [3:0] lowbit(input logic [15:0] l);
        logic [3:0] r;
        r = 4'd0;
        for (int k = 15; k >= 0; k--) begin
            if (l[k]) begin
                r = k[3:0];
            end
        end
        lowbit = r;
    endfunction

    // ************************************************************
    // Combinational single-cycle results
    // ************************************************************
    wire logic [31:0] rot_src  = rotr(i_rm, i_rot);
    wire logic [31:0] w_bswap  = {i_rm[7:0], i_rm[15:8], i_rm[23:16], i_rm[31:24]};
    wire logic [31:0] w_hswap  = {i_rm[23:16], i_rm[31:24], i_rm[7:0], i_rm[15:8]};
    wire logic [31:0] w_lswap  = {{16{i_rm[7]}}, i_rm[7:0], i_rm[15:8]};
    wire logic [63:0] w_sprod  = $signed(i_rn) * $signed(i_rm);
    wire logic [63:0] w_uprod  = i_rn * i_rm;
    wire logic [63:0] w_acc    = {i_acc_hi, i_acc_lo};
    wire logic [63:0] w_smac   = w_acc + w_sprod;
    wire logic [63:0] w_umac   = w_acc + w_uprod;
    // Clip: i_width holds the bit position n, source is i_rm rotated right by i_rot
    wire logic signed [32:0] s_src = {rot_src[31], rot_src};
    wire logic [5:0]  sn_m1   = (i_width == 6'd0) ? 6'd0 : i_width - 6'd1;
    wire logic signed [32:0] s_max = (33'sd1 <<< sn_m1) - 33'sd1;
    wire logic signed [32:0] s_min = -(33'sd1 <<< sn_m1);
    wire logic signed [32:0] u_max = (33'sd1 <<< i_width) - 33'sd1;
    wire logic        s_hi    = s_src > s_max;
    wire logic        s_lo    = s_src < s_min;
    wire logic        u_hi    = s_src > u_max;
    wire logic        u_lo    = s_src < 33'sd0;
    wire logic [31:0] w_sclip = s_hi ? s_max[31:0] : (s_lo ? s_min[31:0] : rot_src);
    wire logic [31:0] w_uclip = u_hi ? u_max[31:0] : (u_lo ? 32'h0000_0000 : rot_src);
    // Field extract
    wire logic [31:0] f_shr   = i_rn >> i_lsb;
    wire logic [31:0] f_mask  = (i_width >= 6'd32) ? 32'hFFFF_FFFF
                                : ((32'h0000_0001 << i_width) - 32'h0000_0001);
    wire logic [4:0]  f_top   = (i_width == 6'd0) ? 5'd0 : 5'(i_width - 6'd1);
    wire logic        f_sign  = f_shr[f_top];
    wire logic [31:0] w_ufext = f_shr & f_mask;
    wire logic [31:0] w_sfext = w_ufext | (f_sign ? ~f_mask : 32'h0000_0000);
    wire logic [31:0] w_hsext = {{16{rot_src[15]}}, rot_src[15:0]};
    wire logic [31:0] w_bsext = {{24{rot_src[7]}}, rot_src[7:0]};
    wire logic [31:0] w_hzext = {16'h0000, rot_src[15:0]};
    wire logic [31:0] w_bzext = {24'h000000, rot_src[7:0]};
    logic [31:0] w_rbit;
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            w_rbit[k] = i_rm[31-k];
        end
    end

    // ************************************************************
    // Store and table sequencer
    // ************************************************************
    cxop_state_e state_q, state_d;
    cxop_op_e    op_q;
    logic [31:0] addr_q;
    logic [15:0] list_q;
    logic [31:0] base_q;
    logic        wb_q;
    logic [31:0] d1_q;
    logic        half_q;
    logic        sat_q;

    wire logic [31:0] blk_span  = {25'd0, popc(i_reglist), 2'b00};
    wire logic        is_desc   = (i_op == CXOP_BLKDESC) || (i_op == CXOP_PUSH);
    wire logic [31:0] blk_start = is_desc ? i_rn - blk_span : i_rn;
    wire logic [31:0] blk_end   = is_desc ? i_rn - blk_span : i_rn + blk_span;
    wire logic [3:0]  cur_idx   = lowbit(list_q);
    wire logic [15:0] list_nx   = list_q & ~(16'h0001 << cur_idx);
    wire logic        st_last   = (list_nx == 16'h0000);
    wire logic        start     = i_valid && (state_q == CXOP_S_IDLE);
    wire logic        blk_op    = (i_op == CXOP_BLKASC) || is_desc;
    wire logic        tj_op     = (i_op == CXOP_TJHALF) || (i_op == CXOP_TJBYTE);
    wire logic        ex_go     = (i_op == CXOP_EXSTORE) && i_ex_held;
    wire logic        dw_op     = i_op == CXOP_DWSTORE;
    wire logic        step      = (state_q != CXOP_S_IDLE) && i_mem_ready;
    wire logic [31:0] tj_addr   = (i_op == CXOP_TJHALF) ? i_rn + (i_rm << 1)
                                : i_rn + i_rm;
    wire logic [31:0] tj_entry  = half_q ? {16'h0000, i_mem_rdata[15:0]}
                                : {24'h000000, i_mem_rdata[7:0]};
    wire logic        clip_sat  = (i_op == CXOP_SCLIP) ? (s_hi || s_lo) : (u_hi || u_lo);
    wire logic        clip_op   = (i_op == CXOP_SCLIP) || (i_op == CXOP_UCLIP);

    always_comb begin
        state_d = state_q;
        case (state_q)
            CXOP_S_IDLE: begin
                if (start && (tj_op)) begin
                    state_d = CXOP_S_TABLE;
                end else if (start && ((blk_op && i_reglist != 16'h0000) || dw_op || ex_go)) begin
                    state_d = CXOP_S_STORE;
                end
            end
            CXOP_S_STORE: begin
                if (step && st_last) begin
                    state_d = CXOP_S_IDLE;
                end
            end
            CXOP_S_TABLE: begin
                if (step) begin
                    state_d = CXOP_S_IDLE;
                end
            end
            default: state_d = CXOP_S_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= CXOP_S_IDLE;
            op_q    <= CXOP_NOP;
            addr_q  <= 32'h0000_0000;
            list_q  <= 16'h0000;
            base_q  <= 32'h0000_0000;
            wb_q    <= 1'b0;
            d1_q    <= 32'h0000_0000;
            half_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start) begin
                op_q   <= i_op;
                half_q <= i_op == CXOP_TJHALF;
                d1_q   <= i_rm;
                wb_q   <= i_writeback || (i_op == CXOP_PUSH);
                base_q <= blk_end;
                if (blk_op) begin
                    addr_q <= blk_start;
                    list_q <= i_reglist;
                end else if (dw_op) begin
                    addr_q <= i_rn + i_imm;
                    list_q <= 16'h0003;
                end else if (tj_op) begin
                    addr_q <= tj_addr;
                    list_q <= 16'h0001;
                end else begin
                    addr_q <= i_rn;
                    list_q <= 16'h0001;
                end
            end else if (step) begin
                addr_q <= addr_q + `CXOP_WORD_BYTES;
                list_q <= list_nx;
            end
        end
    end

    // Sticky saturation flag
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sat_q <= `CXOP_FLAG_RST;
        end else if (start && clip_op && clip_sat) begin
            sat_q <= 1'b1;
        end
    end

    // ************************************************************
    // Result registers
    // ************************************************************
    logic [31:0] res_lo_d;
    logic [31:0] res_hi_d;
    logic        hi_we_d;
    always_comb begin
        res_lo_d = 32'h0000_0000;
        res_hi_d = 32'h0000_0000;
        hi_we_d  = 1'b0;
        case (i_op)
            CXOP_WBSWAP:   res_lo_d = w_bswap;
            CXOP_HPSWAP:   res_lo_d = w_hswap;
            CXOP_LHSWAPSX: res_lo_d = w_lswap;
            CXOP_RBIT:     res_lo_d = w_rbit;
            CXOP_SLMUL: begin
                {res_hi_d, res_lo_d} = w_sprod;
                hi_we_d = 1'b1;
            end
            CXOP_ULMUL: begin
                {res_hi_d, res_lo_d} = w_uprod;
                hi_we_d = 1'b1;
            end
            CXOP_SMAC: begin
                {res_hi_d, res_lo_d} = w_smac;
                hi_we_d = 1'b1;
            end
            CXOP_UMAC: begin
                {res_hi_d, res_lo_d} = w_umac;
                hi_we_d = 1'b1;
            end
            CXOP_SCLIP:    res_lo_d = w_sclip;
            CXOP_UCLIP:    res_lo_d = w_uclip;
            CXOP_SFEXT:    res_lo_d = w_sfext;
            CXOP_UFEXT:    res_lo_d = w_ufext;
            CXOP_HSEXT:    res_lo_d = w_hsext;
            CXOP_BSEXT:    res_lo_d = w_bsext;
            CXOP_HZEXT:    res_lo_d = w_hzext;
            CXOP_BZEXT:    res_lo_d = w_bzext;
            CXOP_EXSTORE:  res_lo_d = {31'd0, ~i_ex_held};
            default:       res_lo_d = 32'h0000_0000;
        endcase
    end

    wire logic tbl_done = (state_q == CXOP_S_TABLE) && step;
    wire logic st_done  = (state_q == CXOP_S_STORE) && step && st_last;
    wire logic now_done = start && !tj_op && !((blk_op && i_reglist != 16'h0000) || dw_op || ex_go);
    wire logic [31:0] tj_target = i_pc + (tj_entry << `CXOP_ENTRY_SCALE);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_res_lo    <= 32'h0000_0000;
            o_res_hi    <= 32'h0000_0000;
            o_res_hi_we <= 1'b0;
            o_done      <= 1'b0;
            o_pc_we     <= 1'b0;
            o_base_we   <= 1'b0;
            o_base_val  <= 32'h0000_0000;
        end else begin
            o_done      <= now_done || st_done || tbl_done;
            o_res_hi_we <= now_done && hi_we_d;
            o_pc_we     <= tbl_done;
            o_base_we   <= st_done && (op_q != CXOP_DWSTORE) && (op_q != CXOP_EXSTORE) && wb_q;
            o_base_val  <= base_q;
            if (now_done) begin
                o_res_lo <= res_lo_d;
                o_res_hi <= res_hi_d;
            end else if (tbl_done) begin
                o_res_lo <= tj_target;
            end else if (st_done && op_q == CXOP_EXSTORE) begin
                o_res_lo <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Memory request port
    // ************************************************************
    assign o_busy      = state_q != CXOP_S_IDLE;
    assign o_sat_flag  = sat_q;
    assign o_reg_idx   = cur_idx;
    assign o_mem_req   = o_busy;
    assign o_mem_we    = state_q == CXOP_S_STORE;
    assign o_mem_addr  = addr_q;
    assign o_mem_wdata = (op_q == CXOP_DWSTORE && cur_idx == 4'd1) ? d1_q : i_reg_rdata;
    assign o_mem_size  = (state_q == CXOP_S_TABLE) ? (half_q ? CXOP_SZ_HALF : CXOP_SZ_BYTE)
                       : ((op_q == CXOP_EXSTORE) ? i_ex_size : CXOP_SZ_WORD);
    assign o_ex_clear  = st_done && (op_q == CXOP_EXSTORE);
endmodule // cxop_exec

//--- testbench/cxop_exec_assertions.sv
// Port-level checks of the execution datapath
// Assumes bind into cxop_exec, one clock domain
module cxop_exec_assertions
    import cxop_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_valid,
    input wire cxop_op_e    i_op,
    input wire logic [31:0] i_rn,
    input wire logic [31:0] i_rm,
    input wire logic [4:0]  i_lsb,
    input wire logic [5:0]  i_width,
    input wire logic        i_ex_held,
    input wire logic        i_mem_ready,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic [31:0] o_res_lo,
    input wire logic [31:0] o_res_hi,
    input wire logic        o_res_hi_we,
    input wire logic        o_sat_flag,
    input wire logic        o_mem_req,
    input wire logic        o_mem_we,
    input wire logic [31:0] o_mem_addr,
    input wire logic        o_pc_we,
    input wire logic        o_base_we
);
    timeunit 1ns;
    timeprecision 1ns;
    // *******
    // Helpers
    // *******
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic               take;
    wire logic [31:0]        wswap;
    wire logic [31:0]        hswap;
    wire logic [63:0]        uprod;
    wire logic signed [63:0] sprod;
    wire logic [31:0]        ufx;
    assign take  = i_valid && !o_busy;
    assign wswap = {i_rm[7:0], i_rm[15:8], i_rm[23:16], i_rm[31:24]};
    assign hswap = {i_rm[23:16], i_rm[31:24], i_rm[7:0], i_rm[15:8]};
    assign uprod = {32'h0, i_rn} * {32'h0, i_rm};
    assign sprod = $signed(i_rn) * $signed(i_rm);
    assign ufx   = 32'(({32'h0, i_rn} >> i_lsb) & ((64'h1 << i_width) - 64'h1));
    // **********
    // Properties
    // **********
    chk_word_swap: assert property (
        take && i_op == CXOP_WBSWAP |=> o_done && o_res_lo == $past(wswap))
        else $error("word swap result wrong");
    chk_half_swap: assert property (
        take && i_op == CXOP_HPSWAP |=> o_res_lo == $past(hswap))
        else $error("halfword pair swap result wrong");
    chk_umul_product: assert property (
        take && i_op == CXOP_ULMUL |=> o_res_hi_we && {o_res_hi, o_res_lo} == $past(uprod))
        else $error("unsigned product wrong");
    chk_smul_product: assert property (
        take && i_op == CXOP_SLMUL |=> o_res_hi_we && {o_res_hi, o_res_lo} == $past(sprod))
        else $error("signed product wrong");
    chk_ufield_clear: assert property (
        take && i_op == CXOP_UFEXT |=> o_res_lo == $past(ufx))
        else $error("unsigned field extract wrong");
    chk_sat_sticky: assert property (
        o_sat_flag |=> o_sat_flag)
        else $error("saturation flag cleared");
    chk_sat_source: assert property (
        $rose(o_sat_flag) |-> $past(take && (i_op == CXOP_SCLIP || i_op == CXOP_UCLIP)))
        else $error("saturation flag set by non-clip op");
    chk_excl_refused: assert property (
        take && i_op == CXOP_EXSTORE && !i_ex_held |=> o_done && o_res_lo == 32'h1 && !o_mem_req)
        else $error("exclusive store without reservation wrong");
    chk_store_step: assert property (
        (o_mem_req && o_mem_we && i_mem_ready) ##1 (o_mem_req && o_mem_we)
        |-> o_mem_addr == $past(o_mem_addr) + 32'h4)
        else $error("store beat address step wrong");
    cover property (o_pc_we);
    cover property ($rose(o_sat_flag));
    cover property (o_base_we);
endmodule // cxop_exec_assertions

//--- testbench/cxop_mem_model.sv
// Memory and register-file model on the far side of the store/table port
// Assumes one core clock; i_slow adds a wait cycle to each beat
module cxop_mem_model
    import cxop_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_slow,
    input  wire logic        i_mem_req,
    input  wire logic        i_mem_we,
    input  wire logic [31:0] i_mem_addr,
    input  wire logic [31:0] i_mem_wdata,
    input  wire cxop_size_e  i_mem_size,
    input  wire logic [3:0]  i_reg_idx,
    output logic             o_mem_ready,
    output logic [31:0]      o_mem_rdata,
    output logic [31:0]      o_reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] wa [0:15];
    logic [31:0] wd [0:15];
    int          wn;
    logic        wait_q;
    logic [7:0]  ent;
    assign o_reg_rdata = {28'hC0DE000, i_reg_idx};
    assign o_mem_ready = i_mem_req && (!i_slow || wait_q);
    assign ent         = i_mem_addr[7:0] ^ 8'h3C;
    // Read data only while ready, inverted otherwise
    assign o_mem_rdata = !o_mem_ready ? ~{4{ent}} :
                         (i_mem_size == CXOP_SZ_BYTE) ? {4{ent}} : {2{8'h01, ent}};
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_q <= 1'b0;
            wn     <= 0;
        end else begin
            wait_q <= i_mem_req && !wait_q;
            if (o_mem_ready && i_mem_we) begin
                wa[wn[3:0]] <= i_mem_addr;
                wd[wn[3:0]] <= i_mem_wdata;
                wn          <= wn + 1;
            end
        end
    end
endmodule // cxop_mem_model

//--- testbench/cxop_exec_bench.sv
// Self-checking bench of the execution datapath
// Assumes cxop_pkg and cxop_exec compiled first
module cxop_exec_bench
    import cxop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_ref_clk, i_rst_n, i_valid, i_writeback, i_ex_held, i_mem_ready, slow;
    cxop_op_e    i_op;
    cxop_size_e  i_ex_size, o_mem_size;
    logic [31:0] i_rn, i_rm, i_acc_lo, i_acc_hi, i_imm, i_pc, i_reg_rdata, i_mem_rdata;
    logic [4:0]  i_rot, i_lsb;
    logic [5:0]  i_width;
    logic [15:0] i_reglist;
    logic        o_busy, o_done, o_res_hi_we, o_base_we, o_pc_we, o_sat_flag;
    logic        o_mem_req, o_mem_we, o_ex_clear;
    logic [31:0] o_res_lo, o_res_hi, o_base_val, o_mem_addr, o_mem_wdata;
    logic [3:0]  o_reg_idx;
    int          num_errors, num_checks, n0;
    int          n_clr = 0;
    cxop_exec i_cxop_exec (.*);
    cxop_mem_model i_cxop_mem_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_slow(slow), .i_mem_req(o_mem_req), .i_mem_we(o_mem_we),
        .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .i_mem_size(o_mem_size),
        .i_reg_idx(o_reg_idx), .o_mem_ready(i_mem_ready), .o_mem_rdata(i_mem_rdata),
        .o_reg_rdata(i_reg_rdata));
    always #25 i_ref_clk = ~i_ref_clk;
    // Counts reservation-consumed pulses, sampled on the clock
    always @(posedge i_ref_clk) begin
        if (o_ex_clear) begin
            n_clr <= n_clr + 1;
        end
    end
    // *****
    // Tasks
    // *****
    task automatic check(input logic [64:0] seen, input logic [64:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run_op(input cxop_op_e op, input logic [31:0] a, input logic [31:0] b);
        int n;
        @(posedge i_ref_clk);
        i_valid <= 1'b1;
        i_op    <= op;
        i_rn    <= a;
        i_rm    <= b;
        @(posedge i_ref_clk);
        i_valid <= 1'b0;
        n = 0;
        #1;
        while (o_done !== 1'b1 && n < 40) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        check(o_done, 1'b1);
    endtask
    task automatic wr(input int k, input logic [31:0] a, input logic [31:0] d);
        check({i_cxop_mem_model.wa[n0 + k], i_cxop_mem_model.wd[n0 + k]}, {a, d});
    endtask
    task automatic t_swaps;
        run_op(CXOP_WBSWAP, 32'h0, 32'h1122_3344);
        check(o_res_lo, 32'h4433_2211);
        run_op(CXOP_HPSWAP, 32'h0, 32'h1122_3344);
        check(o_res_lo, 32'h2211_4433);
        run_op(CXOP_LHSWAPSX, 32'h0, 32'h1234_0080);
        check(o_res_lo, 32'hFFFF_8000);
        run_op(CXOP_RBIT, 32'h0, 32'h0000_0001);
        check({o_sat_flag, o_res_lo}, {1'b0, 32'h8000_0000});
        $display("swap test done");
    endtask
    task automatic t_mul;
        run_op(CXOP_SLMUL, 32'hFFFF_FFFE, 32'h0000_0003);
        check({o_res_hi_we, o_res_hi, o_res_lo}, {1'b1, 64'hFFFF_FFFF_FFFF_FFFA});
        run_op(CXOP_ULMUL, 32'hFFFF_FFFE, 32'h0000_0003);
        check({o_res_hi, o_res_lo}, 64'h0000_0002_FFFF_FFFA);
        i_acc_lo <= 32'h0000_0004;
        i_acc_hi <= 32'h0000_0000;
        run_op(CXOP_SMAC, 32'hFFFF_FFFE, 32'h0000_0003);
        check({o_res_hi, o_res_lo}, 64'hFFFF_FFFF_FFFF_FFFE);
        i_acc_lo <= 32'hFFFF_FFFF;
        i_acc_hi <= 32'h0000_0001;
        run_op(CXOP_UMAC, 32'hFFFF_FFFE, 32'h0000_0003);
        check({o_res_hi, o_res_lo}, 64'h0000_0004_FFFF_FFF9);
        check(o_sat_flag, 1'b0);
        $display("multiply test done");
    endtask
    task automatic t_clip;
        i_width <= 6'h08;
        run_op(CXOP_SCLIP, 32'h0000_0100, 32'h0000_0100);
        check({o_sat_flag, o_res_lo}, {1'b1, 32'h0000_007F});
        run_op(CXOP_UCLIP, 32'hFFFF_FFFB, 32'hFFFF_FFFB);
        check(o_res_lo, 32'h0000_0000);
        run_op(CXOP_UCLIP, 32'h0000_0042, 32'h0000_0042);
        check({o_sat_flag, o_res_lo}, {1'b1, 32'h0000_0042});
        $display("clip test done");
    endtask
    task automatic t_ext;
        cxop_op_e    ops [4];
        logic [31:0] ex [4];
        ops = '{CXOP_HSEXT, CXOP_BSEXT, CXOP_HZEXT, CXOP_BZEXT};
        ex  = '{32'hFFFF_80FF, 32'hFFFF_FFFF, 32'h0000_80FF, 32'h0000_00FF};
        i_lsb <= 5'h04;
        run_op(CXOP_SFEXT, 32'h0000_0F80, 32'h0000_0F80);
        check(o_res_lo, 32'hFFFF_FFF8);
        run_op(CXOP_UFEXT, 32'h0000_0F80, 32'h0000_0F80);
        check(o_res_lo, 32'h0000_00F8);
        i_rot <= 5'h08;
        for (int k = 0; k < 4; k++) begin
            run_op(ops[k], 32'h1280_FF00, 32'h1280_FF00);
            check(o_res_lo, ex[k]);
        end
        $display("extend test done");
    endtask
    task automatic t_store;
        n0 = i_cxop_mem_model.wn;
        slow <= 1'b1;
        i_reglist <= 16'h0005;
        i_writeback <= 1'b1;
        run_op(CXOP_BLKASC, 32'h2000_0100, 32'h0);
        check({o_base_we, o_base_val}, {1'b1, 32'h2000_0108});
        wr(0, 32'h2000_0100, 32'hC0DE_0000);
        wr(1, 32'h2000_0104, 32'hC0DE_0002);
        i_writeback <= 1'b0;
        run_op(CXOP_BLKDESC, 32'h2000_0100, 32'h0);
        check(o_base_we, 1'b0);
        wr(2, 32'h2000_00F8, 32'hC0DE_0000);
        wr(3, 32'h2000_00FC, 32'hC0DE_0002);
        i_reglist <= 16'h0006;
        run_op(CXOP_PUSH, 32'h2000_0400, 32'h0);
        check({o_base_we, o_base_val}, {1'b1, 32'h2000_03F8});
        wr(4, 32'h2000_03F8, 32'hC0DE_0001);
        wr(5, 32'h2000_03FC, 32'hC0DE_0002);
        i_imm <= 32'h0000_0010;
        run_op(CXOP_DWSTORE, 32'h2000_0200, 32'hDEAD_BEEF);
        wr(6, 32'h2000_0210, 32'hC0DE_0000);
        wr(7, 32'h2000_0214, 32'hDEAD_BEEF);
        i_ex_held <= 1'b1;
        i_ex_size <= CXOP_SZ_HALF;
        run_op(CXOP_EXSTORE, 32'h2000_0300, 32'h0000_ABCD);
        check({o_res_lo, i_cxop_mem_model.wa[n0 + 8]}, {32'h0, 32'h2000_0300});
        check(n_clr, 1);
        i_ex_held <= 1'b0;
        i_ex_size <= CXOP_SZ_BYTE;
        run_op(CXOP_EXSTORE, 32'h2000_0300, 32'h0000_ABCD);
        check({o_res_lo, 32'(i_cxop_mem_model.wn - n0)}, {32'h1, 32'h9});
        $display("store test done");
    endtask
    task automatic t_table;
        i_pc <= 32'h0800_0100;
        run_op(CXOP_TJHALF, 32'h2000_0040, 32'h0000_0003);
        check({o_pc_we, o_res_lo}, {1'b1, 32'h0800_03F4});
        run_op(CXOP_TJBYTE, 32'h2000_0040, 32'h0000_0005);
        check({o_pc_we, o_res_lo}, {1'b1, 32'h0800_01F2});
        $display("table test done");
    endtask
    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        {i_ref_clk, i_rst_n, i_valid, i_writeback, i_ex_held, slow} = '0;
        {i_rn, i_rm, i_acc_lo, i_acc_hi, i_imm, i_pc} = '0;
        {i_rot, i_lsb, i_width, i_reglist} = '0;
        i_op = CXOP_NOP;
        i_ex_size = CXOP_SZ_WORD;
        num_errors = 0;
        num_checks = 0;
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_swaps();
        t_mul();
        t_clip();
        t_ext();
        t_store();
        t_table();
        finish_test();
    end
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule // cxop_exec_bench
bind cxop_exec cxop_exec_assertions i_cxop_exec_assertions (.*);
